//--- verilog/uts_pkg.sv
// Purpose: Shared constants and types of the serial port status/control block.
// Assumes: 50 MHz system clock, 8N1 character frames.
// Notes:   Register indices are word addresses on the plain register port.
//
// How it works
// - Transmit select 10 interrupts when a load into the shifter empties the buffer.
// - Transmit select 01 interrupts once the last character has left the shifter.
// - Transmit select 00 interrupts on every load into the shifter.
// - With infrared off the idle-invert bit makes the line idle low, else high.
// - With infrared on the idle-invert bit gives an encoded idle of 1, else 0.
// - The shift-empty flag reads 1 only when shifter and buffer are empty.
// - Receive select 11 interrupts when a character fills the receive buffer.
// - Receive select 10 interrupts when a character leaves 3 in the buffer.
// - Receive select 0x interrupts on every received character.
package uts_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [2:0] ADDR_STA  = 3'h0; // Status and control
	localparam logic [2:0] ADDR_TXD  = 3'h1; // Transmit data, write only
	localparam logic [2:0] ADDR_RXD  = 3'h2; // Receive data, read pops
	localparam logic [2:0] ADDR_IST  = 3'h3; // Interrupt status, W1C
	localparam logic [2:0] ADDR_IMSK = 3'h4; // Interrupt mask
	localparam logic [2:0] ADDR_MODE = 3'h5; // Mode: infrared encoding

	// Status/control field positions
	localparam int BIT_TXSEL_HI = 15;
	localparam int BIT_INV      = 14;
	localparam int BIT_TXSEL_LO = 13;
	localparam int BIT_BRK      = 11;
	localparam int BIT_TXEN     = 10;
	localparam int BIT_TXBF     = 9;
	localparam int BIT_TX_SHIFT_EMPTY     = 8;
	localparam int BIT_RXSEL    = 6;
	localparam int BIT_RXAVAIL  = 0;
	localparam int IRQ_TX       = 0;
	localparam int IRQ_RX       = 1;
	localparam int MODE_INFRARED_ENCODE_ENABLE    = 0;

	// Select encodings
	localparam logic [1:0] TXSEL_EACH  = 2'h0;
	localparam logic [1:0] TXSEL_DONE  = 2'h1;
	localparam logic [1:0] TXSEL_EMPTY = 2'h2;
	localparam logic [1:0] RXSEL_3Q    = 2'h2;
	localparam logic [1:0] RXSEL_FULL  = 2'h3;

	// ****************************************
	// Timing and framing
	// ****************************************
	localparam int CLK_HZ       = 50_000_000;
	localparam int BAUD_HZ      = 115_200;
	localparam int CLKS_PER_BIT = CLK_HZ / BAUD_HZ;
	localparam int DATA_BITS    = 8;
	localparam int BRK_BITS     = 12;
	localparam int IR_NUM       = 3;  // Infrared pulse is 3/16 of a bit
	localparam int IR_DEN       = 16;

	typedef struct packed {
		logic [1:0] tx_sel;
		logic       tx_idle_invert;
		logic       send_sync_break;
		logic       tx_enable;
		logic [1:0] rx_irq_select;
	} uts_ctrl_t;

	localparam uts_ctrl_t CTRL_RST = '{2'h0, 1'b0, 1'b0, 1'b0, 2'h0};
	localparam logic [1:0] IRQ_RST = 2'h0;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_SHIFT = 2'b10,
		TX_STOP  = 2'b11
	} uts_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} uts_rx_state_t;

endpackage : uts_pkg

//--- verilog/uts_fifo.sv
// Purpose: Small character buffer with registered read data.
// Assumes: Nothing of the caller; pushes when full and pops when empty are ignored.
// Notes:   Read data appear the cycle after a pop.
module uts_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          flush,
	input  wire logic          push,
	input  wire logic [W-1:0]  wdata,
	input  wire logic          pop,
	output logic      [W-1:0]  rdata,
	output logic      [AW:0]   count,
	output logic               full,
	output logic               empty
);
	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          do_push;
	logic          do_pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("uts_fifo: DEPTH must be a power of two, at least 2");
	end

	assign count   = cnt_q;
	assign full    = cnt_q == (AW+1)'(DEPTH);
	assign empty   = cnt_q == '0;
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;

	// Storage needs no reset; occupancy decides what is valid
	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem_q[wr_q] <= wdata;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// Registered read port
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (do_pop) begin
			rdata <= mem_q[rd_q];
		end
	end

endmodule : uts_fifo

//--- verilog/uts_uart.sv
// Purpose: Serial port with status/control register, buffers and interrupt.
// Assumes: 8N1 frames; one baud rate fixed by CLKS_PER_BIT.
// Notes:   Receive errors are dropped silently; no error flags are kept.
//
// The register offsets and the strobed register port were left to the implementer.
module uts_uart #(
	parameter int CLKS_PER_BIT = uts_pkg::CLKS_PER_BIT,
	parameter int TX_DEPTH     = 4,
	parameter int RX_DEPTH     = 4
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             serial_tx_pin_level,
	output logic             serial_tx_pin_en,
	input  wire logic        serial_rx_pin,
	output logic             irq
);
	localparam int TAW = $clog2(TX_DEPTH);
	localparam int RAW = $clog2(RX_DEPTH);
	localparam logic [15:0] CPB  = 16'(CLKS_PER_BIT);
	localparam logic [15:0] HALF = 16'(CLKS_PER_BIT / 2);
	localparam logic [15:0] IRLEN =
		16'(CLKS_PER_BIT * uts_pkg::IR_NUM / uts_pkg::IR_DEN);
	localparam logic [3:0] LAST_DATA = 4'(uts_pkg::DATA_BITS - 1);
	localparam logic [3:0] LAST_BRK  = 4'(uts_pkg::BRK_BITS - 1);
	localparam logic [RAW:0] RX_FULL_N = (RAW+1)'(RX_DEPTH - 1);
	localparam logic [RAW:0] RX_3Q_N   = (RAW+1)'(RX_DEPTH * 3 / 4 - 1);

	if (CLKS_PER_BIT < 16 || CLKS_PER_BIT > 65535) begin : g_chk_cpb
		$error("uts_uart: CLKS_PER_BIT out of range 16..65535");
	end
	if (RX_DEPTH % 4 != 0) begin : g_chk_rx
		$error("uts_uart: RX_DEPTH must be a multiple of four");
	end

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_q;
	logic       rst_core_n;

	// Release is synchronous so no flop sees a reset edge mid-cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_core_n = rst_sync_q[1];

	// ****************************************
	// Register port
	// ****************************************
	uts_pkg::uts_ctrl_t  ctrl_q;
	uts_pkg::uts_tx_state_t tx_state_q;
	uts_pkg::uts_rx_state_t rx_state_q;
	logic        infrared_encode_enable_q;
	logic [1:0]  ist_q;
	logic [1:0]  imsk_q;
	logic [1:0]  evt;
	logic        evt_tx;
	logic        evt_rx;
	logic [15:0] rdata_q;
	logic [15:0] sta_word;
	logic        rd_rxd_q;
	logic        wr_sta;
	logic        brk_done;
	logic        tx_full;
	logic        tx_empty;
	logic        tx_shift_empty;
	logic [TAW:0] tx_count;
	logic [7:0]  tx_rdata;
	logic        tx_push;
	logic        tx_pop;
	logic        rx_full;
	logic        rx_empty;
	logic [RAW:0] rx_count;
	logic [7:0]  rx_rdata;
	logic        rx_push;
	logic        rx_pop;

	assign wr_sta  = reg_wr && reg_addr == uts_pkg::ADDR_STA;
	assign tx_push = reg_wr && reg_addr == uts_pkg::ADDR_TXD &&
		ctrl_q.tx_enable;
	assign rx_pop  = reg_rd && reg_addr == uts_pkg::ADDR_RXD && !rx_empty;

	// Control fields; a written break request wins over its own completion
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			ctrl_q <= uts_pkg::CTRL_RST;
		end else if (wr_sta) begin
			ctrl_q.tx_sel <= {reg_wdata[uts_pkg::BIT_TXSEL_HI],
				reg_wdata[uts_pkg::BIT_TXSEL_LO]};
			ctrl_q.tx_idle_invert  <= reg_wdata[uts_pkg::BIT_INV];
			ctrl_q.send_sync_break <= reg_wdata[uts_pkg::BIT_BRK];
			ctrl_q.tx_enable       <= reg_wdata[uts_pkg::BIT_TXEN];
			ctrl_q.rx_irq_select   <= reg_wdata[uts_pkg::BIT_RXSEL +: 2];
		end else if (brk_done) begin
			ctrl_q.send_sync_break <= 1'b0;
		end
	end

	// Mode and mask registers
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			infrared_encode_enable_q <= 1'b0;
			imsk_q <= uts_pkg::IRQ_RST;
		end else if (reg_wr) begin
			if (reg_addr == uts_pkg::ADDR_MODE) begin
				infrared_encode_enable_q <= reg_wdata[uts_pkg::MODE_INFRARED_ENCODE_ENABLE];
			end
			if (reg_addr == uts_pkg::ADDR_IMSK) begin
				imsk_q <= reg_wdata[1:0];
			end
		end
	end

	// Sticky events; a new event beats a write-one-to-clear
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			ist_q <= uts_pkg::IRQ_RST;
		end else if (reg_wr && reg_addr == uts_pkg::ADDR_IST) begin
			ist_q <= (ist_q & ~reg_wdata[1:0]) | evt;
		end else begin
			ist_q <= ist_q | evt;
		end
	end
	assign irq = |(ist_q & imsk_q);

	// Live status word; bit 12 and the receive error bits read zero
	always_comb begin
		sta_word = 16'h0000;
		sta_word[uts_pkg::BIT_TXSEL_HI] = ctrl_q.tx_sel[1];
		sta_word[uts_pkg::BIT_INV]      = ctrl_q.tx_idle_invert;
		sta_word[uts_pkg::BIT_TXSEL_LO] = ctrl_q.tx_sel[0];
		sta_word[uts_pkg::BIT_BRK]      = ctrl_q.send_sync_break;
		sta_word[uts_pkg::BIT_TXEN]     = ctrl_q.tx_enable;
		sta_word[uts_pkg::BIT_TXBF]     = tx_full;
		sta_word[uts_pkg::BIT_TX_SHIFT_EMPTY]     = tx_shift_empty;
		sta_word[uts_pkg::BIT_RXSEL +: 2] = ctrl_q.rx_irq_select;
		sta_word[uts_pkg::BIT_RXAVAIL]  = !rx_empty;
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rdata_q  <= 16'h0000;
			rd_rxd_q <= 1'b0;
		end else begin
			rd_rxd_q <= reg_rd && reg_addr == uts_pkg::ADDR_RXD;
			rdata_q  <= 16'h0000;
			if (reg_rd) begin
				unique case (reg_addr)
					uts_pkg::ADDR_STA:  rdata_q <= sta_word;
					uts_pkg::ADDR_IST:  rdata_q <= {14'h0000, ist_q};
					uts_pkg::ADDR_IMSK: rdata_q <= {14'h0000, imsk_q};
					uts_pkg::ADDR_MODE: rdata_q <= {15'h0000, infrared_encode_enable_q};
					default:            rdata_q <= 16'h0000;
				endcase
			end
		end
	end
	// Receive data come straight from the buffer's output register
	assign reg_rdata = rd_rxd_q ? {8'h00, rx_rdata} : rdata_q;

	// ****************************************
	// Transmitter
	// ****************************************
	logic [15:0] tx_cnt_q;
	logic [3:0]  tx_bits_q;
	logic [7:0]  tx_shift_q;
	logic        tx_is_brk_q;
	logic        tx_load_q;
	logic        tx_tick;
	logic        tx_line;
	logic        tx_shift_empty_q;
	logic        tx_level_d;

	uts_fifo #(
		.DEPTH (TX_DEPTH)
	) u_tx_buf (
		.clk_sys (clk_sys),
		.rst_n   (rst_core_n),
		.flush   (!ctrl_q.tx_enable),
		.push    (tx_push),
		.wdata   (reg_wdata[7:0]),
		.pop     (tx_pop),
		.rdata   (tx_rdata),
		.count   (tx_count),
		.full    (tx_full),
		.empty   (tx_empty)
	);

	assign tx_tick = tx_cnt_q == CPB - 16'h0001;
	assign tx_pop  = ctrl_q.tx_enable && tx_state_q == uts_pkg::TX_IDLE &&
		!ctrl_q.send_sync_break && !tx_empty;
	assign brk_done = tx_state_q == uts_pkg::TX_STOP && tx_tick &&
		tx_is_brk_q;
	assign tx_shift_empty = tx_state_q == uts_pkg::TX_IDLE && tx_empty &&
		!tx_load_q;

	// Bit timer restarts with each frame
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			tx_cnt_q <= 16'h0000;
		end else if (tx_state_q == uts_pkg::TX_IDLE || tx_tick) begin
			tx_cnt_q <= 16'h0000;
		end else begin
			tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	// Frame sequencer; a disable drops the frame at once
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			tx_state_q  <= uts_pkg::TX_IDLE;
			tx_bits_q   <= 4'h0;
			tx_is_brk_q <= 1'b0;
		end else if (!ctrl_q.tx_enable) begin
			tx_state_q <= uts_pkg::TX_IDLE;
		end else begin
			unique case (tx_state_q)
				uts_pkg::TX_IDLE: begin
					if (ctrl_q.send_sync_break) begin
						tx_state_q  <= uts_pkg::TX_START;
						tx_is_brk_q <= 1'b1;
					end else if (!tx_empty) begin
						tx_state_q  <= uts_pkg::TX_START;
						tx_is_brk_q <= 1'b0;
					end
				end
				uts_pkg::TX_START: begin
					if (tx_tick) begin
						tx_state_q <= uts_pkg::TX_SHIFT;
						tx_bits_q  <= 4'h0;
					end
				end
				uts_pkg::TX_SHIFT: begin
					if (tx_tick) begin
						tx_bits_q <= tx_bits_q + 4'h1;
						if (tx_bits_q == (tx_is_brk_q ? LAST_BRK : LAST_DATA)) begin
							tx_state_q <= uts_pkg::TX_STOP;
						end
					end
				end
				uts_pkg::TX_STOP: begin
					if (tx_tick) begin
						tx_state_q <= uts_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

	// Shifter loads the cycle after the pop, when buffer data are out
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			tx_load_q  <= 1'b0;
			tx_shift_q <= 8'h00;
		end else begin
			tx_load_q <= tx_pop;
			if (tx_load_q) begin
				tx_shift_q <= tx_rdata;
			end else if (tx_state_q == uts_pkg::TX_SHIFT && tx_tick) begin
				tx_shift_q <= {1'b0, tx_shift_q[7:1]};
			end
		end
	end

	// Break bits are all zero whatever the shifter holds
	always_comb begin
		unique case (tx_state_q)
			uts_pkg::TX_START: tx_line = 1'b0;
			uts_pkg::TX_SHIFT: tx_line = !tx_is_brk_q && tx_shift_q[0];
			default:           tx_line = 1'b1;
		endcase
	end

	// Infrared sends a short pulse for each zero bit; idle is no pulse
	assign tx_level_d = infrared_encode_enable_q ?
		((!tx_line && tx_cnt_q < IRLEN) ^ ctrl_q.tx_idle_invert) :
		(tx_line ^ ctrl_q.tx_idle_invert);

	// Pin level from a flop so it never glitches
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			serial_tx_pin_level <= 1'b1;
			serial_tx_pin_en    <= 1'b0;
			tx_shift_empty_q    <= 1'b1;
		end else begin
			serial_tx_pin_level <= tx_level_d;
			serial_tx_pin_en    <= ctrl_q.tx_enable;
			tx_shift_empty_q    <= tx_shift_empty;
		end
	end

	// Transmit interrupt source by select
	always_comb begin
		unique case (ctrl_q.tx_sel)
			uts_pkg::TXSEL_EACH:  evt_tx = tx_pop;
			uts_pkg::TXSEL_EMPTY: evt_tx = tx_pop &&
				tx_count == (TAW+1)'(1) && !tx_push;
			uts_pkg::TXSEL_DONE:  evt_tx = ctrl_q.tx_enable &&
				tx_shift_empty && !tx_shift_empty_q;
			default:              evt_tx = 1'b0;
		endcase
	end

	// ****************************************
	// Receiver
	// ****************************************
	logic [2:0]  rx_sync_q;
	logic        rx_level_q;
	logic [15:0] rx_cnt_q;
	logic [3:0]  rx_bits_q;
	logic [7:0]  rx_shift_q;
	logic        rx_tick;

	// Pin filter: a change counts once the last two stages agree
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rx_sync_q  <= 3'h7;
			rx_level_q <= 1'b1;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], serial_rx_pin};
			if (rx_sync_q[1] == rx_sync_q[2]) begin
				rx_level_q <= rx_sync_q[2];
			end
		end
	end

	assign rx_tick = rx_cnt_q == (rx_state_q == uts_pkg::RX_START ?
		HALF : CPB) - 16'h0001;

	// Sample at mid-bit; a bad start or stop bit drops the character
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rx_state_q <= uts_pkg::RX_IDLE;
			rx_cnt_q   <= 16'h0000;
			rx_bits_q  <= 4'h0;
			rx_shift_q <= 8'h00;
		end else begin
			rx_cnt_q <= (rx_tick || rx_state_q == uts_pkg::RX_IDLE) ?
				16'h0000 : rx_cnt_q + 16'h0001;
			unique case (rx_state_q)
				uts_pkg::RX_IDLE: begin
					if (!rx_level_q) begin
						rx_state_q <= uts_pkg::RX_START;
					end
				end
				uts_pkg::RX_START: begin
					if (rx_tick) begin
						rx_bits_q  <= 4'h0;
						rx_state_q <= rx_level_q ? uts_pkg::RX_IDLE :
							uts_pkg::RX_DATA;
					end
				end
				uts_pkg::RX_DATA: begin
					if (rx_tick) begin
						rx_shift_q <= {rx_level_q, rx_shift_q[7:1]};
						rx_bits_q  <= rx_bits_q + 4'h1;
						if (rx_bits_q == LAST_DATA) begin
							rx_state_q <= uts_pkg::RX_STOP;
						end
					end
				end
				uts_pkg::RX_STOP: begin
					if (rx_tick) begin
						rx_state_q <= uts_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	assign rx_push = rx_state_q == uts_pkg::RX_STOP && rx_tick &&
		rx_level_q && !rx_full;

	uts_fifo #(
		.DEPTH (RX_DEPTH)
	) u_rx_buf (
		.clk_sys (clk_sys),
		.rst_n   (rst_core_n),
		.flush   (1'b0),
		.push    (rx_push),
		.wdata   (rx_shift_q),
		.pop     (rx_pop),
		.rdata   (rx_rdata),
		.count   (rx_count),
		.full    (rx_full),
		.empty   (rx_empty)
	);

	// Receive interrupt source by fill level after the transfer
	always_comb begin
		unique case (ctrl_q.rx_irq_select)
			uts_pkg::RXSEL_FULL: evt_rx = rx_push &&
				!rx_pop && rx_count == RX_FULL_N;
			uts_pkg::RXSEL_3Q:   evt_rx = rx_push &&
				!rx_pop && rx_count == RX_3Q_N;
			default:             evt_rx = rx_push;
		endcase
	end
	// One driver for the event vector: receive is bit 1, transmit bit 0
	assign evt = {evt_rx, evt_tx};

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_core_n);

	a_tx_each_irq: assert property (
		ctrl_q.tx_sel == 2'h0 && tx_pop |=> ist_q[0])
		else $error("load did not raise transmit event");
	a_tx_empty_irq: assert property (
		ctrl_q.tx_sel == 2'h2 && tx_pop && !tx_push &&
		tx_count == (TAW+1)'(1) |=> ist_q[0] && tx_empty)
		else $error("emptying load did not raise transmit event");
	a_tx_done_irq: assert property (
		ctrl_q.tx_sel == 2'h1 && tx_state_q == uts_pkg::TX_STOP &&
		tx_tick && tx_empty && ctrl_q.tx_enable ##1 tx_shift_empty
		|=> ist_q[0])
		else $error("transmit done did not raise event");
	a_idle_plain_lvl: assert property (
		tx_state_q == uts_pkg::TX_IDLE && !infrared_encode_enable_q
		|=> serial_tx_pin_level != $past(ctrl_q.tx_idle_invert))
		else $error("plain idle level wrong");
	a_idle_ir_lvl: assert property (
		tx_state_q == uts_pkg::TX_IDLE && infrared_encode_enable_q
		|=> serial_tx_pin_level == $past(ctrl_q.tx_idle_invert))
		else $error("infrared idle level wrong");
	a_break_zero_bits: assert property (
		tx_state_q == uts_pkg::TX_SHIFT && tx_is_brk_q && !infrared_encode_enable_q
		|=> serial_tx_pin_level == $past(ctrl_q.tx_idle_invert))
		else $error("break bit not zero");
	a_break_self_clr: assert property (
		brk_done && !wr_sta |=> !ctrl_q.send_sync_break)
		else $error("break request not cleared");
	a_tx_disable_abort: assert property (
		!ctrl_q.tx_enable |=> tx_state_q == uts_pkg::TX_IDLE &&
		tx_empty && !serial_tx_pin_en)
		else $error("disable did not abort transmit");
	a_tx_full_flag: assert property (
		tx_full == (tx_count == (TAW+1)'(TX_DEPTH)))
		else $error("buffer full flag wrong");
	a_shift_empty_flag: assert property (
		tx_shift_empty |-> tx_empty && tx_state_q == uts_pkg::TX_IDLE)
		else $error("shift empty flag while busy");
	a_rx_full_irq: assert property (
		ctrl_q.rx_irq_select == 2'h3 && rx_push && !rx_pop &&
		rx_count == RX_FULL_N |=> ist_q[1] && rx_full)
		else $error("full receive buffer raised no event");
	a_rx_3q_irq: assert property (
		ctrl_q.rx_irq_select == 2'h2 && rx_push && !rx_pop &&
		rx_count == RX_3Q_N |=> ist_q[1])
		else $error("three-quarter fill raised no event");
	a_rx_each_irq: assert property (
		!ctrl_q.rx_irq_select[1] && rx_push |=> ist_q[1])
		else $error("received character raised no event");

	c_tx_frame: cover property (tx_pop ##[1:20] tx_state_q ==
		uts_pkg::TX_SHIFT);
	c_break_sent: cover property (brk_done);
	c_rx_full: cover property (rx_push ##1 rx_full);
	c_irq_high: cover property ($rose(irq));

endmodule : uts_uart

//--- verif/uts_node.sv
// Purpose: Remote serial node that feeds the receive line and reads the
//          transmit line.
// Assumes: 8N1 frames of CPB clocks per bit.
// Notes:   The line rests high between frames, like a pulled-up idle.
module uts_node #(
	parameter int CPB = 16
) (
	input  wire logic clk_sys,
	input  wire logic serial_tx_pin,
	output logic      serial_rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial serial_rx_pin = 1'b1;
	// One character: start, data LSB first, stop
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_rx_pin <= f[i];
			repeat (CPB) @(posedge clk_sys);
		end
	endtask : send
	// One character off the transmit line, sampled mid-bit off the edge
	task automatic recv(output logic [7:0] c);
		while (serial_tx_pin !== 1'b0) @(negedge clk_sys);
		repeat (CPB / 2) @(negedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (CPB) @(negedge clk_sys);
			c[i] = serial_tx_pin;
		end
	endtask : recv
endmodule : uts_node

//--- verif/tb_uts_uart.sv
// Purpose: Self-checking bench for the serial port status/control block.
// Assumes: 16 clocks per bit to keep frames short.
// Notes: Select 11 of the transmit field is never written.
module tb_uts_uart;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys   = 1'b0;
	logic        rst_n     = 1'b0;
	logic [2:0]  reg_addr  = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [15:0] reg_rdata;
	logic        pin;
	logic        pin_en;
	logic        rx_line;
	logic        irq;
	int          failures  = 0;
	int          cmp_count = 0;
	int          n;
	logic [7:0]  c;
	localparam int CPB = 16;
	always #10 clk_sys = ~clk_sys;
	uts_uart #(.CLKS_PER_BIT(CPB)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_tx_pin_level(pin),
		.serial_tx_pin_en(pin_en), .serial_rx_pin(rx_line), .irq(irq));
	uts_node #(.CPB(CPB)) node (.clk_sys(clk_sys), .serial_tx_pin(pin),
		.serial_rx_pin(rx_line));
	// ****************************************
	// Access tasks
	// ****************************************
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic w(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : w
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd
	task automatic give_verdict;
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		w(3);
		rd(uts_pkg::ADDR_STA, 16'h0100);
		wr(uts_pkg::ADDR_IMSK, 16'h0003);
		wr(uts_pkg::ADDR_STA, 16'h0400);
		w(3);
		chk({14'h0, pin_en, pin}, 16'h0003);
		// Five writes fill one shifter plus four slots
		for (int i = 0; i < 5; i++) wr(uts_pkg::ADDR_TXD, 16'h0011);
		rd(uts_pkg::ADDR_STA, 16'h0600);
		rd(uts_pkg::ADDR_IST, 16'h0001);
		wr(uts_pkg::ADDR_STA, 16'h0000);
		w(3);
		chk({15'h0, pin_en}, 16'h0000);
		rd(uts_pkg::ADDR_STA, 16'h0100);
		wr(uts_pkg::ADDR_IST, 16'h0003);
		wr(uts_pkg::ADDR_STA, 16'h2400);
		wr(uts_pkg::ADDR_TXD, 16'h003C);
		node.recv(c);
		rd(uts_pkg::ADDR_IST, 16'h0000);
		chk({8'h00, c}, 16'h003C);
		w(200);
		rd(uts_pkg::ADDR_IST, 16'h0001);
		chk({15'h0, irq}, 16'h0001);
		wr(uts_pkg::ADDR_IMSK, 16'h0002);
		w(1);
		chk({15'h0, irq}, 16'h0000);
		wr(uts_pkg::ADDR_IMSK, 16'h0003);
		wr(uts_pkg::ADDR_IST, 16'h0001);
		// Break: low for the start bit and twelve zeros
		wr(uts_pkg::ADDR_STA, 16'h2C00);
		n = 0;
		while (pin !== 1'b0 && n < 500) begin w(1); n++; end
		n = 0;
		while (pin === 1'b0 && n < 400) begin w(1); n++; end
		chk(n[15:0], 16'h00D0);
		w(40);
		rd(uts_pkg::ADDR_STA, 16'h2500);
		rd(uts_pkg::ADDR_IST, 16'h0001);
		wr(uts_pkg::ADDR_STA, 16'h8400);
		wr(uts_pkg::ADDR_IST, 16'h0001);
		wr(uts_pkg::ADDR_TXD, 16'h00A1);
		wr(uts_pkg::ADDR_TXD, 16'h00A2);
		w(20);
		rd(uts_pkg::ADDR_IST, 16'h0001);
		wr(uts_pkg::ADDR_IST, 16'h0001);
		w(80);
		rd(uts_pkg::ADDR_IST, 16'h0000);
		w(200);
		rd(uts_pkg::ADDR_IST, 16'h0001);
		// Idle levels, plain and infrared, once the last frame has ended
		wr(uts_pkg::ADDR_STA, 16'h4400);
		w(12);
		chk({15'h0, pin}, 16'h0000);
		wr(uts_pkg::ADDR_MODE, 16'h0001);
		wr(uts_pkg::ADDR_STA, 16'h0400);
		w(3);
		chk({15'h0, pin}, 16'h0000);
		wr(uts_pkg::ADDR_STA, 16'h4400);
		w(3);
		chk({15'h0, pin}, 16'h0001);
		wr(uts_pkg::ADDR_MODE, 16'h0000);
		// Receive fill levels
		wr(uts_pkg::ADDR_STA, 16'h0400);
		wr(uts_pkg::ADDR_IST, 16'h0003);
		node.send(8'h5A);
		w(20);
		rd(uts_pkg::ADDR_IST, 16'h0002);
		rd(uts_pkg::ADDR_STA, 16'h0501);
		wr(uts_pkg::ADDR_IST, 16'h0002);
		wr(uts_pkg::ADDR_STA, 16'h0480);
		node.send(8'h11);
		w(20);
		rd(uts_pkg::ADDR_IST, 16'h0000);
		node.send(8'h22);
		w(20);
		rd(uts_pkg::ADDR_IST, 16'h0002);
		wr(uts_pkg::ADDR_IST, 16'h0002);
		wr(uts_pkg::ADDR_STA, 16'h04C0);
		node.send(8'h33);
		w(20);
		rd(uts_pkg::ADDR_IST, 16'h0002);
		rd(uts_pkg::ADDR_RXD, 16'h005A);
		rd(3'h7, 16'h0000);
		give_verdict();
	end
	// Watchdog well past the fewer than two thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		give_verdict();
	end
endmodule : tb_uts_uart
